// ==== shared/fpa_pkg.sv ====
// Package for the parallel ferroelectric memory host controller
package fpa_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;   // Byte address width
  localparam int COL_W = 3;     // Column bits, eight bytes per row
  localparam int ROW_W = 12;    // Row bits, 4K rows
  localparam int DATA_W = 8;    // Data lines width
  // ---------------------------------------------------------------
  // Timing, ns and cycles at 100 ns per clock
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int PRECHARGE_MIN_NS = 70;      // Select high least time
  localparam int ADDRESS_ACCESS_NS = 140;    // New-row read access
  localparam int RANDOM_READ_NS = 140;       // New-row read period
  localparam int RANDOM_WRITE_NS = 140;      // New-row write period
  localparam int PAGE_ACCESS_NS = 40;        // Column read access
  localparam int WE_PULSE_NS = 18;           // Write strobe low least time
  localparam int COL_STABLE_NS = 15;         // Column hold least time
  // Least times round up; none below one cycle
  localparam int PRECHARGE_CYC = (PRECHARGE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ADDRESS_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RCYC_CYC = (RANDOM_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int WCYC_CYC = (RANDOM_WRITE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PAGE_CYC = (PAGE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WEP_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int COLS_CYC = (COL_STABLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum {ST_IDLE, ST_PRECH, ST_ACCESS, ST_WLOW, ST_WHIGH, ST_DONE} fpa_state_t;
  // User request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fpa_req_t;
  // Memory pins driven by the host
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [ROW_W-1:0] row_address;
    logic [COL_W-1:0] column_address;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } fpa_pins_t;
  // All state except the data pin synchroniser
  typedef struct packed {
    fpa_state_t st;
    logic [CNT_W-1:0] cnt;
    logic row_open;
    logic write;
    fpa_pins_t pins;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } fpa_regs_t;
endpackage : fpa_pkg

// ==== logic/fpa_host.sv ====
// Host controller driving a page-mode parallel ferroelectric memory
`timescale 1ns/1ps
// Operation
// RL1 - Rows hold eight bytes, low bits column
// RL2 - Column accesses in row keep select low
// RL3 - Page read: new column gives new byte
// RL4 - Page write: each strobe writes new column
// RL5 - Select high starts device pre-charge
// RL6 - Host holds select high pre-charge time
// RL7 - Row change makes device close and pre-charge
// RL8 - Row change data valid within access time
// RL9 - New-row accesses no faster than cycle
// RL10 - Select may stay low; device tracks addresses
// RL11 - Column steps no faster than page rate
// RL12 - Keep write strobe high around power
// RL13 - Assert select only during memory accesses; select stays low while idle with a row open, until close_row
// RL14 - Array is 4K rows of eight bytes
// RL15 - Keep column bits stable least interval
// RL16 - Device latches data on first rising strobe
// RL17 - Device floats data when output disabled
// RL18 - Column-only change keeps row open
module fpa_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input fpa_pkg::fpa_req_t req,
  input wire logic close_row,
  output logic [fpa_pkg::DATA_W-1:0] rd_data,
  output logic rd_valid,
  output fpa_pkg::fpa_pins_t pins,
  input wire logic [fpa_pkg::DATA_W-1:0] dq_in
);
  fpa_pkg::fpa_regs_t r_q, r_d;
  logic [fpa_pkg::DATA_W-1:0] dq_s1_q, dq_s2_q;  // Data pin synchroniser
  logic same_row;                                // Request hits open row
  // New-row read wait: the longer of access time and random read period
  localparam int ROW_RD_CYC = (fpa_pkg::ACCESS_CYC > fpa_pkg::RCYC_CYC) ?
    fpa_pkg::ACCESS_CYC : fpa_pkg::RCYC_CYC;
  // Take edge to sampled rd_valid: wait, pin edge, second flop, done state
  localparam int RD_FIRST = fpa_pkg::PAGE_CYC + 3;
  localparam int RD_LAST = ROW_RD_CYC + 3;
  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------
  // Two stages; their latency is part of every read wait below, so a
  // shorter wait would hand back the byte of the previous column
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end
  // RL1 row compare
  assign same_row = r_q.row_open && (req.addr[fpa_pkg::ADDR_W-1:fpa_pkg::COL_W]
                    == r_q.pins.row_address);
  // Ready is combinational; data outputs and pins come from the register
  // Trade-off: one request in flight, no queue, so the pin timing stays simple
  assign req_ready = (r_q.st == fpa_pkg::ST_IDLE);
  assign rd_data = r_q.rdata;
  assign rd_valid = r_q.rvalid;
  assign pins = r_q.pins;
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    case (r_q.st)
      fpa_pkg::ST_IDLE: begin
        if (close_row && r_q.row_open) begin
          // RL13 select released when idle on request
          r_d.pins.ce_n = 1'b1;
          r_d.pins.oe_n = 1'b1;
          r_d.row_open = 1'b0;
          r_d.cnt = 4'(fpa_pkg::PRECHARGE_CYC);
          r_d.st = fpa_pkg::ST_PRECH;
        end else if (req_valid) begin
          r_d.write = req.write;
          r_d.pins.column_address = req.addr[fpa_pkg::COL_W-1:0];
          r_d.pins.dq_out = req.wdata;
          r_d.pins.oe_n = req.write;
          r_d.pins.dq_oe = req.write;
          if (same_row) begin
            // RL2 RL18 column-only step, select stays low
            if (req.write) begin
              // RL4 page write pulse with the new column
              r_d.pins.we_n = 1'b0;
              r_d.cnt = 4'(fpa_pkg::WEP_CYC);
              r_d.st = fpa_pkg::ST_WLOW;
            end else begin
              // RL11 page access wait; extra cycle as pins move one edge late
              r_d.cnt = 4'(fpa_pkg::PAGE_CYC) + fpa_pkg::CNT_ONE;
              r_d.st = fpa_pkg::ST_ACCESS;
            end
          end else begin
            // RL7 RL10 new row, select kept low
            r_d.pins.row_address = req.addr[fpa_pkg::ADDR_W-1:fpa_pkg::COL_W];
            r_d.pins.ce_n = 1'b0;
            r_d.row_open = 1'b1;
            // RL9 full random cycle for new row
            if (req.write) begin
              r_d.cnt = 4'(fpa_pkg::WCYC_CYC);
              r_d.st = fpa_pkg::ST_WLOW;
            end else begin
              // Extra cycle: the sampled byte must be a full access old
              r_d.cnt = 4'(ROW_RD_CYC) + fpa_pkg::CNT_ONE;
              r_d.st = fpa_pkg::ST_ACCESS;
            end
            r_d.pins.we_n = ~req.write;
          end
        end
      end
      fpa_pkg::ST_PRECH: begin
        // RL5 RL6 hold select high for pre-charge
        r_d.cnt = r_q.cnt - fpa_pkg::CNT_ONE;
        if (r_q.cnt <= fpa_pkg::CNT_ONE) begin
          r_d.st = fpa_pkg::ST_IDLE;
        end
      end
      fpa_pkg::ST_ACCESS: begin
        // RL8 RL11 wait access time before sampling
        r_d.cnt = r_q.cnt - fpa_pkg::CNT_ONE;
        if (r_q.cnt <= fpa_pkg::CNT_ONE) begin
          r_d.st = fpa_pkg::ST_DONE;
        end
      end
      fpa_pkg::ST_DONE: begin
        // RL3 byte of current column captured
        // Second flop already holds it: the wait counts cover both stages
        r_d.rdata = dq_s2_q;
        r_d.rvalid = 1'b1;
        r_d.st = fpa_pkg::ST_IDLE;
      end
      fpa_pkg::ST_WLOW: begin
        // RL4 strobe low, data held
        r_d.cnt = r_q.cnt - fpa_pkg::CNT_ONE;
        if (r_q.cnt <= fpa_pkg::CNT_ONE) begin
          // RL16 rising strobe latches data
          r_d.pins.we_n = 1'b1;
          r_d.cnt = 4'(fpa_pkg::COLS_CYC);
          r_d.st = fpa_pkg::ST_WHIGH;
        end
      end
      fpa_pkg::ST_WHIGH: begin
        // RL15 keep column and data stable after strobe
        r_d.cnt = r_q.cnt - fpa_pkg::CNT_ONE;
        if (r_q.cnt <= fpa_pkg::CNT_ONE) begin
          r_d.pins.dq_oe = 1'b0;
          r_d.st = fpa_pkg::ST_IDLE;
        end
      end
      default: r_d.st = fpa_pkg::ST_IDLE;
    endcase
  end
  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // RL12 reset holds select and strobe high, outputs floated
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r_q <= '0;
      r_q.st <= fpa_pkg::ST_IDLE;
      r_q.pins.ce_n <= 1'b1;
      r_q.pins.we_n <= 1'b1;
      r_q.pins.oe_n <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // RL12 strobe high out of reset
  a_strobe_reset_high: assert property (@(posedge sys_clk) !rst_n |=> pins.we_n) // RL12
    else $error("write strobe low after reset");
  // RL6 select high for the pre-charge state and the idle edge after it
  a_precharge_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pins.ce_n) |-> pins.ce_n [*2]) // RL6
    else $error("select high too short");
  // RL7 row steady under strobe
  a_row_stable_page: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!pins.ce_n && !pins.we_n) |=> $stable(pins.row_address)) // RL7
    else $error("row changed under write strobe");
  // RL17 no contention on reads
  a_no_drive_on_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pins.oe_n |-> !pins.dq_oe) // RL17
    else $error("host drives bus while reading");
  // RL16 data held at rise
  a_write_data_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out)) // RL16
    else $error("data not held at strobe rise");
  // RL15 column held at rise
  a_col_stable: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(pins.we_n) |-> $stable(pins.column_address)) // RL15
    else $error("column moved at strobe rise");
  // RL8 read answer after access wait and synchroniser
  a_read_latency: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req_valid && req_ready && !req.write && !close_row) |-> ##[RD_FIRST:RD_LAST] rd_valid) // RL8
    else $error("read answer late");
  // RL18 column step keeps select
  a_page_keep_ce: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req_valid && req_ready && same_row && !close_row) |=> !pins.ce_n) // RL18
    else $error("select toggled on column step");
  // RL4 strobe only in a selected, driven write
  a_strobe_qualified: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !pins.we_n |-> !pins.ce_n && pins.oe_n && pins.dq_oe) // RL4
    else $error("write strobe low outside a driven write");
  // RL13 select released on request
  a_idle_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (close_row && req_ready && !pins.ce_n) |=> pins.ce_n) // RL13
    else $error("select not released on close");
  // Main scenarios: page and new-row transfers, pre-charge
  c_page_read: cover property (@(posedge sys_clk)
    req_valid && req_ready && same_row && !req.write);
  c_page_write: cover property (@(posedge sys_clk)
    req_valid && req_ready && same_row && req.write);
  c_new_row_read: cover property (@(posedge sys_clk)
    req_valid && req_ready && !same_row && !close_row && !req.write);
  c_new_row_write: cover property (@(posedge sys_clk)
    req_valid && req_ready && !same_row && !close_row && req.write);
  c_precharge: cover property (@(posedge sys_clk) r_q.st == fpa_pkg::ST_PRECH);
endmodule : fpa_host

// ==== verification/fpa_mem_model.sv ====
// Behavioural model of the page-mode ferroelectric memory
`timescale 1ns/1ps
module fpa_mem_model (
  input wire logic sys_clk,
  input fpa_pkg::fpa_pins_t pins,
  output logic [fpa_pkg::DATA_W-1:0] dq_in
);
  // ---------------------------------------------------------------
  // Array and bus state
  // ---------------------------------------------------------------
  logic [7:0] mem_q [0:32767]; // Array, unwritten bytes stay unknown
  fpa_pkg::fpa_pins_t prev_q; // Pins one edge ago
  logic [7:0] last_q = 8'h00; // Last level on the data lines
  wire logic [14:0] addr = {pins.row_address, pins.column_address};
  always_comb begin
    if (!pins.ce_n && !pins.oe_n && pins.we_n) begin
      dq_in = mem_q[addr];
    end else begin
      // No pull-up: a released bus must not look like good data
      dq_in = ~last_q;
    end
  end
  // write on first rising select or strobe
  always @(posedge sys_clk) begin
    prev_q <= pins;
    last_q <= dq_in;
    if (!prev_q.ce_n && !prev_q.we_n && (pins.we_n || pins.ce_n)) begin
      mem_q[{prev_q.row_address, prev_q.column_address}] <= prev_q.dq_out;
    end
  end
endmodule : fpa_mem_model

// ==== verification/fpa_host_test.sv ====
// Self-checking bench for the page-mode memory host controller
`timescale 1ns/1ps
module fpa_host_test;
  // ---------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  fpa_pkg::fpa_req_t req = '0;
  logic close_row = 1'b0;
  logic [7:0] rd_data;
  logic rd_valid;
  fpa_pkg::fpa_pins_t pins;
  logic [7:0] dq_in;
  logic [7:0] shadow [0:32767]; // Bench copy of the array
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 8365;
  fpa_host i_fpa_host (.sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .close_row(close_row), .rd_data(rd_data),
    .rd_valid(rd_valid), .pins(pins), .dq_in(dq_in));
  fpa_mem_model i_fpa_mem_model (.sys_clk(sys_clk), .pins(pins), .dq_in(dq_in));
  // Clock, 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // Expected byte comes from the bench copy only
  function automatic logic [7:0] want_byte(input logic [14:0] a);
    return shadow[a];
  endfunction : want_byte
  // One request; entered and left at a falling edge
  task automatic access(input logic wr, input logic [14:0] a, input logic [7:0] d);
    int k;
    for (k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge sys_clk);
    if (k == 20) begin
      n_mismatch++;
      print_verdict();
    end
    check("dq_oe idle", pins.dq_oe, 1'b0);
    req_valid = 1'b1;
    req = '{write: wr, addr: a, wdata: d};
    @(negedge sys_clk);
    req_valid = 1'b0;
    if (wr) begin
      shadow[a] = d;
    end else begin
      for (k = 0; k < 20 && rd_valid !== 1'b1; k++) @(negedge sys_clk);
      if (k == 20) begin
        n_mismatch++;
        print_verdict();
      end
      check("rd_data", rd_data, want_byte(a));
      check("address", {pins.row_address, pins.column_address}, a);
      check("ce_n", pins.ce_n, 1'b0);
      check("oe_n", pins.oe_n, 1'b0);
    end
  endtask : access
  // Leave select high so the device pre-charges
  task automatic close_it();
    int k;
    close_row = 1'b1;
    for (k = 0; k < 20 && pins.ce_n !== 1'b1; k++) @(negedge sys_clk);
    close_row = 1'b0;
    check("ce_n closed", pins.ce_n, 1'b1);
    check("we_n closed", pins.we_n, 1'b1);
  endtask : close_it
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int i;
    logic [31:0] r;
    logic [14:0] a;
    repeat (5) @(negedge sys_clk);
    check("ce_n reset", pins.ce_n, 1'b1);
    rst_n = 1'b1;
    // Fill a row column by column, then read it back in page mode
    for (i = 0; i < 8; i++) access(1'b1, {12'h5a3, i[2:0]}, {5'h02, i[2:0]});
    for (i = 7; i >= 0; i--) access(1'b0, {12'h5a3, i[2:0]}, 8'h00);
    // Row boundary: last byte of the array, then the first
    access(1'b1, 15'h7fff, 8'ha5);
    access(1'b1, 15'h0000, 8'h5a);
    access(1'b0, 15'h7fff, 8'h00);
    access(1'b0, 15'h0000, 8'h00);
    close_it();
    // Random mix over four rows, so page hits and row changes both occur
    for (i = 0; i < 300; i++) begin
      r = $random(seed);
      a = {10'h2c4, r[1:0], r[4:2]};
      access(r[16] || shadow[a] === 8'hxx, a, r[15:8]);
      if (r[20:18] == 3'h0) close_it();
    end
    print_verdict();
  end
endmodule : fpa_host_test
